// *** logic/lfc_pkg.sv ***
// Constants and types for the link frame command handler (host side).
// Assumes modulo-8 control fields and a 32-bit AHB-Lite register port.
`default_nettype none
package lfc_pkg;
	// ==========================================================
	// Register map, byte addresses.
	localparam logic [7:0] LFC_A_CTRL = 8'h00;
	localparam logic [7:0] LFC_A_STAT = 8'h04;
	localparam logic [7:0] LFC_A_REJF = 8'h08;
	localparam logic [7:0] LFC_A_RXCNT = 8'h0c;
	// ==========================================================
	// Control register bits; 8 and up are write-one pulses.
	localparam int LFC_CB_BUSY = 0;
	localparam int LFC_CB_FRMR = 1;
	localparam int LFC_CB_CONN = 8;
	localparam int LFC_CB_DISC = 9;
	localparam int LFC_CB_SENDI = 10;
	localparam int LFC_CB_POLL = 11;
	localparam logic [1:0] LFC_CTRL_RST = 2'h0;
	// ==========================================================
	// Control field codes with P/F and N(R) cleared.
	localparam logic [7:0] LFC_C_RR = 8'h01;
	localparam logic [7:0] LFC_C_RNR = 8'h05;
	localparam logic [7:0] LFC_C_REJ = 8'h09;
	localparam logic [7:0] LFC_C_SARM = 8'h0f;
	localparam logic [7:0] LFC_C_DM = 8'h0f;
	localparam logic [7:0] LFC_C_SABM = 8'h2f;
	localparam logic [7:0] LFC_C_DISC = 8'h43;
	localparam logic [7:0] LFC_C_UA = 8'h63;
	localparam logic [7:0] LFC_C_FRMR = 8'h87;
	localparam logic [7:0] LFC_S_MASK = 8'h0f;
	localparam logic [7:0] LFC_U_MASK = 8'hef;
	localparam int LFC_PF_BIT = 4;
	// ==========================================================
	// Sequence numbering.
	localparam int LFC_SEQ_W = 3;
	localparam logic [2:0] LFC_SEQ_ONE = 3'h1;
	localparam logic [2:0] LFC_WIN_MAX = 3'h7;
	localparam int LFC_MAX_INFO = 128;
	// ==========================================================
	// Deferred unnumbered command executed after its UA.
	localparam logic [1:0] LFC_EX_NONE = 2'h0;
	localparam logic [1:0] LFC_EX_ABM = 2'h1;
	localparam logic [1:0] LFC_EX_ARM = 2'h2;
	localparam logic [1:0] LFC_EX_DISC = 2'h3;
	// ==========================================================
	// Link phases.
	typedef enum logic [4:0] {
		LFC_PH_DISC = 5'b00001,
		LFC_PH_SETUP = 5'b00010,
		LFC_PH_ABM = 5'b00100,
		LFC_PH_ARM = 5'b01000,
		LFC_PH_CLEAR = 5'b10000
	} lfc_phase_t;
endpackage : lfc_pkg
`default_nettype wire

// *** logic/lfc_host.sv ***
// Host link station: control field processing for a frame link.
// Assumes a framer that delivers decoded control octets and sends
// frames on request; software orders it over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none
module lfc_host #(
	parameter int MAX_INFO = lfc_pkg::LFC_MAX_INFO
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic rx_valid,
	input wire logic [7:0] rx_ctrl,
	input wire logic rx_cmd,
	input wire logic rx_has_info,
	input wire logic [11:0] rx_info_len,
	output logic rx_deliver,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_ctrl,
	output logic tx_cmd,
	output logic [23:0] tx_info,
	output logic tx_info_en
);
	import lfc_pkg::*;

	// ==========================================================
	// Bus slave.
	logic wr_pend_r;
	logic [7:0] addr_r;
	logic [1:0] ctrl_r;
	logic [31:0] rd_mux;
	logic [15:0] rxcnt_r;
	wire acc = hsel & htrans[1] & hready;
	wire wr_ctrl = wr_pend_r & (addr_r == LFC_A_CTRL);
	wire own_busy = ctrl_r[LFC_CB_BUSY];
	wire frmr_style = ctrl_r[LFC_CB_FRMR];

	// Zero wait states: read data is fetched in the address phase.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wr_pend_r <= 1'b0;
			addr_r <= 8'h00;
			hrdata <= 32'h00000000;
		end else begin
			wr_pend_r <= acc & hwrite;
			addr_r <= haddr[7:0];
			if (acc & ~hwrite) begin
				hrdata <= rd_mux;
			end
		end
	end

	// Both bus answers are constant, but come from flip-flops.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// Level control bits; the pulse bits are not stored.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= LFC_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_r <= hwdata[1:0];
		end
	end

	// ==========================================================
	// Station state.
	lfc_phase_t phase_r, phase_nxt;
	logic [2:0] vs_r, vr_r, va_r;
	logic [2:0] vs_nxt, vr_nxt, va_nxt;
	logic [2:0] lost_r;
	logic [1:0] exec_r;
	logic busy_d_r, peer_busy_r, rej_sent_r, frmr_act_r;
	logic peer_rej_r, fin_r;
	logic [23:0] rejf_r;
	logic p_ua_r, p_dm_r, p_frmr_r, p_rej_r, p_sup_r;
	logic p_sabm_r, p_disc_r, p_i_r, p_poll_r;
	logic tx_ua_r;

	wire connected = (phase_r == LFC_PH_ABM) | (phase_r == LFC_PH_ARM);
	wire disc_ph = (phase_r == LFC_PH_DISC);

	// ==========================================================
	// Receive decode.
	wire is_i = ~rx_ctrl[0];
	wire is_s = (rx_ctrl[1:0] == 2'b01);
	wire is_u = (rx_ctrl[1:0] == 2'b11);
	wire pf = rx_ctrl[LFC_PF_BIT];
	wire [2:0] ns = rx_ctrl[3:1];
	wire [2:0] nr = rx_ctrl[7:5];
	wire [7:0] s_code = rx_ctrl & LFC_S_MASK;
	wire [7:0] u_code = rx_ctrl & LFC_U_MASK;
	wire s_rr = is_s & (s_code == LFC_C_RR);
	wire s_rnr = is_s & (s_code == LFC_C_RNR);
	wire s_rej = is_s & (s_code == LFC_C_REJ);
	wire known_s = s_rr | s_rnr | s_rej;
	wire u_sabm = is_u & rx_cmd & (u_code == LFC_C_SABM);
	wire u_sarm = is_u & rx_cmd & (u_code == LFC_C_SARM);
	wire u_disc = is_u & rx_cmd & (u_code == LFC_C_DISC);
	wire u_ua = is_u & ~rx_cmd & (u_code == LFC_C_UA);
	wire u_dm = is_u & ~rx_cmd & (u_code == LFC_C_DM);
	wire u_frmr = is_u & ~rx_cmd & (u_code == LFC_C_FRMR);
	wire known_u = u_sabm | u_sarm | u_disc | u_ua | u_dm | u_frmr;

	// Modulo-8 distances; wrap is free in three bits.
	wire [2:0] nr_off = nr - va_r;
	wire [2:0] out_cnt = vs_r - va_r;
	wire nr_ok = (nr_off <= out_cnt);

	// Reject causes; Y and Z yield to W.
	wire err_x = rx_has_info & (known_s | known_u);
	wire err_w = ~(is_i | known_s | known_u) | err_x;
	wire err_y = is_i & (rx_info_len > 12'(MAX_INFO)) & ~err_w;
	wire err_z = (is_i | known_s) & ~nr_ok & ~err_w;
	wire bad = err_w | err_y | err_z;
	wire rej_cond = rx_valid & connected & bad & ~frmr_act_r;
	wire b13 = frmr_style & ~rx_cmd;
	wire [23:0] rej_field = {4'h0, err_z, err_y, err_x, err_w,
		vr_r, b13, vs_r, 1'b0, rx_ctrl};

	// Frames that are acted on in the transfer phases.
	wire rx_ok = rx_valid & connected & ~bad;
	wire rx_i = rx_ok & is_i;
	wire rx_s = rx_ok & known_s;
	wire i_in_seq = (ns == vr_r);
	wire i_take = rx_i & i_in_seq & ~own_busy & ~frmr_act_r;
	wire i_oos = rx_i & ~i_in_seq & ~frmr_act_r;
	wire rx_mode = rx_valid & ~bad & ~disc_ph & (u_sabm | u_sarm | u_disc);
	// Commands refused while disconnected: DM to any poll.
	wire dm_need = rx_valid & disc_ph & rx_cmd & pf & ~u_sabm;
	wire sabm_dc = rx_valid & disc_ph & u_sabm;
	wire ua_setup = rx_valid & u_ua & (phase_r == LFC_PH_SETUP);
	wire ua_clear = rx_valid & u_ua & (phase_r == LFC_PH_CLEAR);
	wire dm_wait = rx_valid & u_dm & ~connected & ~disc_ph;

	// ==========================================================
	// Software orders.
	wire conn_req = wr_ctrl & hwdata[LFC_CB_CONN] & disc_ph;
	wire disc_req = wr_ctrl & hwdata[LFC_CB_DISC] & connected;
	wire sendi_req = wr_ctrl & hwdata[LFC_CB_SENDI];
	wire poll_req = wr_ctrl & hwdata[LFC_CB_POLL] & connected;

	// ==========================================================
	// Transmit selection, highest priority first.
	wire tx_free = ~tx_valid & ~rx_valid;
	wire win_ok = (out_cnt != LFC_WIN_MAX);
	wire i_ok = p_i_r & connected & ~peer_busy_r & win_ok & ~frmr_act_r;
	wire t_ua = tx_free & p_ua_r;
	wire t_dm = tx_free & ~p_ua_r & p_dm_r;
	wire hi1 = p_ua_r | p_dm_r;
	wire t_frmr = tx_free & ~hi1 & p_frmr_r;
	wire hi2 = hi1 | p_frmr_r;
	wire t_rej = tx_free & ~hi2 & p_rej_r;
	wire hi3 = hi2 | p_rej_r;
	wire t_sup = tx_free & ~hi3 & p_sup_r;
	wire hi4 = hi3 | p_sup_r;
	wire t_sabm = tx_free & ~hi4 & p_sabm_r;
	wire t_disc = tx_free & ~hi4 & ~p_sabm_r & p_disc_r;
	wire hi5 = hi4 | p_sabm_r | p_disc_r;
	wire t_poll = tx_free & ~hi5 & p_poll_r;
	wire t_i = tx_free & ~hi5 & ~p_poll_r & i_ok;
	wire t_resp = t_ua | t_dm | t_frmr | t_rej | t_sup;
	wire tx_done = tx_valid & tx_ready;
	wire ex_now = tx_done & tx_ua_r;
	wire [7:0] sup_code = own_busy ? LFC_C_RNR : LFC_C_RR;
	wire [7:0] nr_f = {vr_r, 5'h00};
	wire [7:0] fin_f = {3'h0, fin_r, 4'h0};
	wire [7:0] poll_f = {3'h0, 1'b1, 4'h0};
	wire [7:0] ctrl_sel =
		t_ua ? (LFC_C_UA | fin_f) :
		t_dm ? (LFC_C_DM | fin_f) :
		t_frmr ? (LFC_C_FRMR | fin_f) :
		t_rej ? (LFC_C_REJ | nr_f | fin_f) :
		t_sup ? (sup_code | nr_f | fin_f) :
		t_sabm ? (LFC_C_SABM | poll_f) :
		t_disc ? (LFC_C_DISC | poll_f) :
		t_poll ? (sup_code | nr_f | poll_f) :
		{vr_r, 1'b0, vs_r, 1'b0};
	wire t_any = t_resp | t_sabm | t_disc | t_poll | t_i;

	// Frame request holds until the framer takes it.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tx_valid <= 1'b0;
			tx_ctrl <= 8'h00;
			tx_cmd <= 1'b0;
			tx_info_en <= 1'b0;
			tx_ua_r <= 1'b0;
		end else if (t_any) begin
			tx_valid <= 1'b1;
			tx_ctrl <= ctrl_sel;
			tx_cmd <= ~t_resp;
			tx_info_en <= t_frmr;
			tx_ua_r <= t_ua;
		end else if (tx_done) begin
			tx_valid <= 1'b0;
			tx_ua_r <= 1'b0;
		end
	end

	// Reject field is captured on the reject condition and held until the next one.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rejf_r <= 24'h000000;
		end else if (rej_cond) begin
			rejf_r <= rej_field;
		end
	end
	assign tx_info = rejf_r;

	// ==========================================================
	// Pending frames: a new request wins over its own take.
	wire busy_chg = (own_busy != busy_d_r);
	wire poll_in = rx_valid & rx_cmd & pf & ~bad;
	wire set_rej = i_oos & ~rej_sent_r;
	wire set_sup = i_take | busy_chg | ((rx_i | rx_s) & poll_in);
	wire set_frmr = rej_cond | (frmr_act_r & poll_in & ~rx_mode);
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			p_ua_r <= 1'b0;
			p_dm_r <= 1'b0;
			p_frmr_r <= 1'b0;
			p_rej_r <= 1'b0;
			p_sup_r <= 1'b0;
		end else begin
			p_ua_r <= (p_ua_r & ~t_ua) | rx_mode | sabm_dc;
			p_dm_r <= (p_dm_r & ~t_dm) | dm_need;
			p_frmr_r <= (p_frmr_r & ~t_frmr) | set_frmr;
			p_rej_r <= (p_rej_r & ~t_rej) | set_rej;
			p_sup_r <= (p_sup_r & ~t_sup) | set_sup;
		end
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			p_sabm_r <= 1'b0;
			p_disc_r <= 1'b0;
			p_i_r <= 1'b0;
			p_poll_r <= 1'b0;
		end else begin
			p_sabm_r <= (p_sabm_r & ~t_sabm) | conn_req;
			p_disc_r <= (p_disc_r & ~t_disc) | disc_req;
			p_i_r <= (p_i_r & ~t_i) | sendi_req;
			p_poll_r <= (p_poll_r & ~t_poll) | poll_req;
		end
	end

	// Final bit owed to the last polled command.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			fin_r <= 1'b0;
		end else begin
			fin_r <= (fin_r & ~t_resp) | poll_in | dm_need;
		end
	end

	// ==========================================================
	// Deferred action of a received mode-setting command.
	wire [1:0] exec_set = (u_sabm | sabm_dc) ? LFC_EX_ABM :
		u_sarm ? LFC_EX_ARM : LFC_EX_DISC;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			exec_r <= LFC_EX_NONE;
		end else if (rx_mode | sabm_dc) begin
			exec_r <= exec_set;
		end else if (ex_now) begin
			exec_r <= LFC_EX_NONE;
		end
	end
	wire ex_abm = ex_now & (exec_r == LFC_EX_ABM);
	wire ex_arm = ex_now & (exec_r == LFC_EX_ARM);
	wire ex_disc = ex_now & (exec_r == LFC_EX_DISC);
	wire reset_all = ex_abm | ua_setup;
	wire mode_act = reset_all | ex_arm | ex_disc | ua_clear;

	// Phase changes; the DISC sender waits for UA or DM first.
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			LFC_PH_DISC: begin
				if (ex_abm) phase_nxt = LFC_PH_ABM;
				else if (t_sabm) phase_nxt = LFC_PH_SETUP;
			end
			LFC_PH_SETUP: begin
				if (ua_setup | ex_abm) phase_nxt = LFC_PH_ABM;
				else if (dm_wait) phase_nxt = LFC_PH_DISC;
			end
			LFC_PH_ABM, LFC_PH_ARM: begin
				if (ex_abm) phase_nxt = LFC_PH_ABM;
				else if (ex_arm) phase_nxt = LFC_PH_ARM;
				else if (ex_disc) phase_nxt = LFC_PH_DISC;
				else if (t_disc) phase_nxt = LFC_PH_CLEAR;
			end
			LFC_PH_CLEAR: begin
				if (ua_clear | dm_wait) phase_nxt = LFC_PH_DISC;
			end
			default: phase_nxt = LFC_PH_DISC;
		endcase
	end

	// ==========================================================
	// Sequence variables; SABM resets all three, SARM only V(R); mode commands never acknowledge.
	assign vs_nxt = reset_all ? 3'h0 :
		(rx_s & s_rej) ? nr :
		t_i ? vs_r + LFC_SEQ_ONE : vs_r;
	assign vr_nxt = (reset_all | ex_arm) ? 3'h0 :
		i_take ? vr_r + LFC_SEQ_ONE : vr_r;
	assign va_nxt = reset_all ? 3'h0 :
		(rx_i | rx_s) ? nr : va_r;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= LFC_PH_DISC;
			vs_r <= 3'h0;
			vr_r <= 3'h0;
			va_r <= 3'h0;
		end else begin
			phase_r <= phase_nxt;
			vs_r <= vs_nxt;
			vr_r <= vr_nxt;
			va_r <= va_nxt;
		end
	end

	// Outstanding frames dropped by a mode change, for software.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lost_r <= 3'h0;
		end else if (mode_act) begin
			lost_r <= out_cnt;
		end
	end

	// ==========================================================
	// Exception flags.
	wire clr_exc = reset_all | ex_arm | ex_disc | ua_clear;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			busy_d_r <= 1'b0;
			peer_busy_r <= 1'b0;
			rej_sent_r <= 1'b0;
			frmr_act_r <= 1'b0;
			peer_rej_r <= 1'b0;
		end else begin
			busy_d_r <= own_busy;
			peer_busy_r <= ~clr_exc & (rx_s ? s_rnr : peer_busy_r);
			rej_sent_r <= set_rej | (rej_sent_r & ~i_take & ~clr_exc);
			frmr_act_r <= rej_cond | (frmr_act_r & ~clr_exc);
			peer_rej_r <= (rx_valid & u_frmr) | (peer_rej_r & ~clr_exc);
		end
	end

	// Delivery strobe and count of accepted information frames.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rx_deliver <= 1'b0;
			rxcnt_r <= 16'h0000;
		end else begin
			rx_deliver <= i_take;
			rxcnt_r <= rxcnt_r + {15'h0000, i_take};
		end
	end

	// ==========================================================
	// Read multiplexer; unmapped addresses read zero.
	wire [31:0] stat_w = {5'h00, lost_r, 2'h0, p_i_r, peer_rej_r,
		frmr_act_r, rej_sent_r, peer_busy_r, own_busy, 1'b0, va_r,
		1'b0, vr_r, 3'h0, phase_r};
	assign rd_mux = (haddr[7:0] == LFC_A_CTRL) ? {30'h0, ctrl_r} :
		(haddr[7:0] == LFC_A_STAT) ? stat_w :
		(haddr[7:0] == LFC_A_REJF) ? {8'h00, rejf_r} :
		(haddr[7:0] == LFC_A_RXCNT) ? {16'h0000, rxcnt_r} : 32'h0;
endmodule : lfc_host
`default_nettype wire

// *** verif/lfc_host_properties.sv ***
// Checker: bus response and link-side timing and format properties of lfc_host.
// Assumes it sees only the lfc_host ports; the bind is at the foot.
`timescale 1ns/1ns
`default_nettype none
module lfc_host_chk
	import lfc_pkg::*;
#(
	parameter int MAX_INFO = 128
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic hresp,
	input wire logic rx_valid,
	input wire logic [7:0] rx_ctrl,
	input wire logic rx_cmd,
	input wire logic rx_has_info,
	input wire logic rx_deliver,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_ctrl,
	input wire logic tx_cmd,
	input wire logic [23:0] tx_info,
	input wire logic tx_info_en
);
	// ==========================================================
	// Decoding of the unnumbered code, with P/F masked off.
	wire [7:0] tx_u = tx_ctrl & LFC_U_MASK;
	wire [7:0] rx_u = rx_ctrl & LFC_U_MASK;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// Properties.
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("bus response not OKAY");
	tx_hold_a: assert property (tx_valid && !tx_ready |=>
		tx_valid && $stable(tx_ctrl) && $stable(tx_info))
		else $error("frame request dropped or changed");
	ua_plain_a: assert property (
		tx_valid && tx_u == LFC_C_UA |-> !tx_info_en && !tx_cmd)
		else $error("UA carries a field or is a command");
	dm_plain_a: assert property (
		tx_valid && !tx_cmd && tx_u == LFC_C_DM |-> !tx_info_en)
		else $error("DM carries a field");
	rej_zero_a: assert property (tx_valid && tx_info_en |->
		!tx_info[8] && tx_info[23:20] == 4'h0 && tx_u == LFC_C_FRMR)
		else $error("reject field reserved bits set");
	rej_flags_a: assert property (tx_valid && tx_info_en |->
		(!tx_info[17] || tx_info[16]) &&
		!(tx_info[16] && (tx_info[18] || tx_info[19])))
		else $error("reject flags combined wrongly");
	sabm_ua_a: assert property (rx_valid && rx_cmd &&
		rx_u == LFC_C_SABM && rx_ctrl[4] && !rx_has_info |->
		##[1:60] tx_valid && tx_ctrl == 8'h73 && !tx_cmd)
		else $error("no UA with final bit after SABM");
	deliver_cause_a: assert property (rx_deliver |->
		$past(rx_valid) && !$past(rx_ctrl[0]) && $past(rx_cmd))
		else $error("delivery without a received I frame");
	i_format_a: assert property (
		tx_valid && !tx_ctrl[0] |-> tx_cmd && !tx_info_en)
		else $error("I frame not a plain command");
endmodule : lfc_host_chk
bind lfc_host lfc_host_chk #(.MAX_INFO(MAX_INFO)) i_lfc_host_chk (
	.mclk, .reset_n, .hresp, .rx_valid, .rx_ctrl, .rx_cmd,
	.rx_has_info, .rx_deliver, .tx_valid, .tx_ready, .tx_ctrl,
	.tx_cmd, .tx_info, .tx_info_en);
`default_nettype wire

// *** verif/lfc_peer_model.sv ***
// Partner: the peer station's framer end, taking and logging frames.
// Assumes the bench feeds received frames into the host directly.
`timescale 1ns/1ns
`default_nettype none
module lfc_peer_model (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic slow,
	input wire logic tx_valid,
	input wire logic [7:0] tx_ctrl,
	input wire logic tx_cmd,
	input wire logic [23:0] tx_info,
	input wire logic tx_info_en,
	output logic tx_ready,
	output logic [7:0] n_frames
);
	logic [7:0] log_ctrl [0:255];
	logic log_cmd [0:255];
	logic [23:0] log_info [0:255];
	logic [1:0] wait_r;
	// A slow peer stalls three cycles so held requests get exercised.
	assign tx_ready = tx_valid && (!slow || wait_r == 2'h3);
	// Takes every frame kind, supervisory commands too.
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			wait_r <= 2'h0;
			n_frames <= 8'h00;
		end else if (tx_ready) begin
			wait_r <= 2'h0;
			log_ctrl[n_frames] <= tx_ctrl;
			log_cmd[n_frames] <= tx_cmd;
			log_info[n_frames] <= tx_info_en ? tx_info : 24'h0;
			n_frames <= n_frames + 8'h01;
		end else if (tx_valid) begin
			wait_r <= wait_r + 2'h1;
		end
	end
endmodule : lfc_peer_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Bench: drives lfc_host over AHB-Lite and its receive side.
// Assumes lfc_peer_model answers on the transmit side.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import lfc_pkg::*;
	logic mclk, reset_n, hsel, hwrite, hreadyout, hresp, slow;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic rx_valid, rx_cmd, rx_has_info, rx_deliver;
	logic [7:0] rx_ctrl, tx_ctrl, n_frames, n_seen, f_idx;
	logic [11:0] rx_info_len;
	logic tx_valid, tx_ready, tx_cmd, tx_info_en;
	logic [23:0] tx_info;
	int failures, n_compared;
	lfc_host i_lfc_host (.mclk, .reset_n, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
		.hrdata, .hresp, .rx_valid, .rx_ctrl, .rx_cmd, .rx_has_info,
		.rx_info_len, .rx_deliver, .tx_valid, .tx_ready, .tx_ctrl,
		.tx_cmd, .tx_info, .tx_info_en);
	lfc_peer_model i_lfc_peer_model (.mclk, .reset_n, .slow,
		.tx_valid, .tx_ctrl, .tx_cmd, .tx_info, .tx_info_en,
		.tx_ready, .n_frames);
	// ==========================================================
	// Tasks.
	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", what, e, g);
		end
	endtask : chk
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		bus(a, 1'b0, 32'h0, q);
		chk($sformatf("register %h", a), e, q & m);
	endtask : rd
	// A one-cycle received frame; I frames carry a field.
	task automatic rx(input logic [7:0] c, input logic cmd);
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_ctrl <= c;
		rx_cmd <= cmd;
		rx_has_info <= !c[0];
		@(posedge mclk);
		rx_valid <= 1'b0;
	endtask : rx
	// Skips unrelated frames, such as plain acknowledgements.
	task automatic expf(input logic [7:0] m, input logic [7:0] e,
		input logic cmd);
		bit found;
		found = 1'b0;
		for (int t = 0; t < 400 && !found; t++) begin
			@(posedge mclk);
			#1;
			while (!found && n_seen != n_frames) begin
				f_idx = n_seen;
				found = (i_lfc_peer_model.log_ctrl[f_idx] & m) === (e & m);
				n_seen++;
			end
		end
		chk($sformatf("frame %h", e), 32'h1, {31'h0, found});
		chk("tx_cmd", {31'h0, cmd}, {31'h0, i_lfc_peer_model.log_cmd[f_idx]});
	endtask : expf
	task automatic print_verdict;
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	// ==========================================================
	// Clock and watchdog.
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		failures++;
		print_verdict();
	end
	// ==========================================================
	// Main sequence; expected values come from the field layouts.
	initial begin
		{reset_n, hsel, hwrite, rx_valid, rx_cmd, rx_has_info} = '0;
		{haddr, hwdata, htrans, rx_ctrl, slow} = '0;
		hsize = 3'h2;
		rx_info_len = 12'h010;
		n_seen = 8'h00;
		f_idx = 8'h00;
		failures = 0;
		n_compared = 0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rd(LFC_A_STAT, 32'hffffffff, 32'h1);
		rd(LFC_A_CTRL, 32'hffffffff, 32'h0);
		rd(8'h10, 32'hffffffff, 32'h0);
		rx(8'h53, 1'b1);
		expf(8'hff, 8'h1f, 1'b0);
		rx(8'h1f, 1'b1);
		expf(8'hff, 8'h1f, 1'b0);
		rx(8'h3f, 1'b1);
		expf(8'hff, 8'h73, 1'b0);
		wr(LFC_A_CTRL, 32'h400);
		expf(8'hff, 8'h00, 1'b1);
		wr(LFC_A_CTRL, 32'h400);
		expf(8'hff, 8'h02, 1'b1);
		rx(8'h40, 1'b1);
		rd(LFC_A_STAT, 32'h0004770f, 32'h2104);
		rx(8'h56, 1'b1);
		expf(8'hff, 8'h39, 1'b0);
		rd(LFC_A_STAT, 32'h0004770f, 32'h42104);
		rx(8'h42, 1'b1);
		rd(LFC_A_STAT, 32'h0004770f, 32'h2204);
		rd(LFC_A_RXCNT, 32'hffffffff, 32'h2);
		slow <= 1'b1;
		rx(8'h51, 1'b1);
		expf(8'hff, 8'h51, 1'b0);
		wr(LFC_A_CTRL, 32'h1);
		expf(8'hef, 8'h45, 1'b0);
		wr(LFC_A_CTRL, 32'h0);
		expf(8'hef, 8'h41, 1'b0);
		wr(LFC_A_CTRL, 32'h402);
		expf(8'hff, 8'h44, 1'b1);
		rx(8'ha1, 1'b0);
		expf(8'hff, 8'h87, 1'b0);
		chk("tx_info", 32'h0856a1, {8'h0,
			i_lfc_peer_model.log_info[f_idx]});
		rd(LFC_A_REJF, 32'hffffffff, 32'h0856a1);
		rx(8'h3f, 1'b1);
		expf(8'hff, 8'h73, 1'b0);
		rd(LFC_A_STAT, 32'h0700070f, 32'h01000004);
		wr(LFC_A_CTRL, 32'h802);
		expf(8'hff, 8'h11, 1'b1);
		rx(8'h1f, 1'b1);
		expf(8'hff, 8'h73, 1'b0);
		rd(LFC_A_STAT, 32'h0000071f, 32'h8);
		wr(LFC_A_CTRL, 32'h200);
		expf(8'hef, 8'h43, 1'b1);
		rd(LFC_A_STAT, 32'h1f, 32'h10);
		rx(8'h73, 1'b0);
		rd(LFC_A_STAT, 32'h1f, 32'h1);
		rx(8'h3f, 1'b1);
		expf(8'hff, 8'h73, 1'b0);
		rx(8'h53, 1'b1);
		expf(8'hff, 8'h73, 1'b0);
		rd(LFC_A_STAT, 32'h1f, 32'h1);
		wr(LFC_A_CTRL, 32'h100);
		expf(8'hff, 8'h3f, 1'b1);
		rd(LFC_A_STAT, 32'h1f, 32'h2);
		rx(8'h73, 1'b0);
		rd(LFC_A_STAT, 32'h0000770f, 32'h4);
		rx_info_len <= 12'h200;
		rx(8'h00, 1'b1);
		expf(8'hff, 8'h87, 1'b0);
		chk("tx_info", 32'h040000, {8'h0,
			i_lfc_peer_model.log_info[f_idx]});
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
